// file: mem_access_pkg.sv
package mem_access_pkg;

	// Program space geometry.
	localparam int PROG_ADDR_W = 24;  // Program-space address width.
	localparam int PC_W        = 23;  // Program counter width.
	localparam logic [23:0] USER_TOP    = 24'h7FFFFF; // Last user address.
	localparam logic [23:0] RESET_ADDR  = 24'h000000; // First fetch.
	localparam logic [23:0] START_PTR   = 24'h000002; // Start-of-code word.
	localparam logic [23:0] VEC1_LO     = 24'h000004; // First vector table.
	localparam logic [23:0] VEC1_HI     = 24'h0000FF;
	localparam logic [23:0] VEC2_LO     = 24'h000100; // Second vector table.
	localparam logic [23:0] VEC2_HI     = 24'h0001FF;
	localparam logic [23:0] CFG_WORD1   = 24'h00ABFC; // Config word one.
	localparam logic [23:0] CFG_WORD2   = 24'h00ABFE; // Config word two.
	localparam logic [23:0] PC_STEP     = 24'h000002; // Execution step.
	localparam int TBL_CFG_BIT = 7;   // Table page bit opening config space.

	// Data space geometry.
	localparam int EA_W       = 16;   // Effective address width.
	localparam int DATA_W     = 16;   // Data word width.
	localparam int RAM_WORDS  = 4096; // 8 Kbytes of data memory.
	localparam int RAM_AW     = 12;   // Word index width.
	localparam logic [15:0] RAM_TOP = 16'h1FFF; // Last implemented byte.
	localparam logic [15:0] SFR_TOP = 16'h07FF; // Top of register area.
	localparam int PSV_BIT    = 15;   // Selects the visibility window.
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;

	// Configuration copy sequencer states.
	typedef enum logic [2:0] {
		CFG_RD1,
		CFG_WAIT1,
		CFG_RD2,
		CFG_WAIT2,
		CFG_DONE
	} cfg_state_e;

endpackage : mem_access_pkg

// file: data_ram.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Byte-lane data memory with a registered read port.
module data_ram (
	input  wire logic        clock_i,   // Core clock.
	input  wire logic [11:0] raddr_i,   // Read word index.
	output logic      [15:0] rdata_o,   // Registered read data.
	input  wire logic [11:0] waddr_i,   // Write word index.
	input  wire logic [1:0]  wstrb_i,   // Per-lane write strobes.
	input  wire logic [15:0] wdata_i    // Write data.
);

	logic [7:0] lane_lo [0:mem_access_pkg::RAM_WORDS-1]; // Even bytes.
	logic [7:0] lane_hi [0:mem_access_pkg::RAM_WORDS-1]; // Odd bytes.

	// Both lanes share one word decode; each has its own write line.
	always_ff @(posedge clock_i) begin
		if (wstrb_i[0]) begin
			lane_lo[waddr_i] <= wdata_i[7:0];
		end
		if (wstrb_i[1]) begin
			lane_hi[waddr_i] <= wdata_i[15:8];
		end
		rdata_o <= {lane_hi[raddr_i], lane_lo[raddr_i]};
	end

endmodule : data_ram
`default_nettype wire

// file: prog_addr.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Program counter: even-aligned, steps by two, starts at the reset word.
module prog_addr (
	input  wire logic        clock_i,  // Core clock.
	input  wire logic        rst_i,    // Asynchronous reset.
	input  wire logic        run_i,    // Execution allowed.
	input  wire logic        inc_i,    // Step forward.
	input  wire logic        dec_i,    // Step backward.
	input  wire logic        load_i,   // Jump.
	input  wire logic [22:0] target_i, // Jump target.
	output logic      [22:0] pc_o      // Program counter.
);

	logic [22:0] pc_q; // Current counter.
	logic [22:0] pc_d; // Next counter.

	// Next value; a jump target has bit zero forced low so the lower word is always used.
	always_comb begin
		pc_d = pc_q;
		if (run_i) begin
			if (load_i) begin
				pc_d = {target_i[22:1], 1'b0}; // R5
			end else if (inc_i) begin
				pc_d = pc_q + mem_access_pkg::PC_STEP[22:0]; // R5
			end else if (dec_i) begin
				pc_d = pc_q - mem_access_pkg::PC_STEP[22:0]; // R5
			end
		end
	end

	// Reset lands on the jump word.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pc_q <= mem_access_pkg::RESET_ADDR[22:0]; // R6
		end else begin
			pc_q <= pc_d;
		end
	end

	assign pc_o = pc_q;

	a_pc_even: assert property (@(posedge clock_i) disable iff (rst_i)
		pc_q[0] == 1'b0) else $error("program counter odd"); // R5
	a_pc_step: assert property (@(posedge clock_i) disable iff (rst_i)
		run_i && inc_i && !load_i |=> pc_q == $past(pc_q) + 23'h000002)
		else $error("program counter step wrong"); // R5

endmodule : prog_addr
`default_nettype wire

// file: memory_space_access.sv
// How it works
// R1: 24-bit program address from counter or table.
// R2: User program access limited to lower half.
// R3: Table ops reach config only with page bit7.
// R4: Even lower word, odd upper word, top zero. The code always takes the lower word, prog_rdata_i[15:0].
// R5: Counter word-aligned, steps by two.
// R6: Reset fetch at zero; start pointer at two.
// R7: Two vector tables give per-source handlers.
// R8: Reset copies top two words to config.
// R9: Separate read and write address units.
// R10: 16-bit byte effective addresses, 64 Kbytes.
// R11: Address bit 15 selects visibility window.
// R12: 8 Kbytes memory; outside reads zero.
// R13: Low byte even address, high byte odd.
// R14: Post-increment adds one byte, two word.
// R15: Byte read picks lane, returns low byte.
// R16: Shared word decode, per-lane write strobes.
// R17: Odd word access raises address error.
// R18: Misaligned read completes; write is suppressed.
// R19: Byte load changes register low byte only.
// R20: Sign-extend and zero-extend operations.
// R21: Upper data half maps via visibility page.
// R22: Unused register-area addresses read zero.
// R23: Misalignment flagged in the access cycle.
`timescale 1ns/1ps
`default_nettype none

module memory_space_access (
	input  wire logic        clock_i,          // Core clock, 50 MHz.
	input  wire logic        rst_i,            // Asynchronous reset.
	// Program fetch side.
	input  wire logic        pc_inc_i,         // Step counter forward.
	input  wire logic        pc_dec_i,         // Step counter backward.
	input  wire logic        pc_load_i,        // Load jump target.
	input  wire logic [22:0] pc_target_i,      // Jump target.
	output logic      [23:0] prog_addr_o,      // Program memory address.
	output logic             prog_rd_o,        // Program read strobe.
	input  wire logic [23:0] prog_rdata_i,     // Program memory word.
	output logic             busy_o,           // Config copy in progress.
	output logic      [15:0] config_word1_o,   // Copied config word one.
	output logic      [15:0] config_word2_o,   // Copied config word two.
	// Table access.
	input  wire logic        tbl_req_i,        // Table read or write op.
	input  wire logic [7:0]  table_page_register_i, // Table page.
	input  wire logic [15:0] tbl_offset_i,     // Table offset.
	output logic             tbl_denied_o,     // Table access refused.
	// Visibility window.
	input  wire logic        psv_en_i,         // Visibility enabled.
	input  wire logic [7:0]  visibility_page_register_i, // Window page.
	// Read address generation unit.
	input  wire logic        rd_req_i,         // Data read request.
	input  wire logic        rd_byte_i,        // Byte-sized read.
	input  wire logic [15:0] rd_ea_i,          // Read effective address.
	input  wire logic        rd_postinc_i,     // Post-increment pointer.
	output logic      [15:0] rd_ea_next_o,     // Updated read pointer.
	output logic             rd_valid_o,       // Read data valid.
	output logic      [15:0] rd_data_o,        // Read result, registered.
	// Write address generation unit.
	input  wire logic        wr_req_i,         // Data write request.
	input  wire logic        wr_byte_i,        // Byte-sized write.
	input  wire logic [15:0] wr_ea_i,          // Write effective address.
	input  wire logic        wr_postinc_i,     // Post-increment pointer.
	input  wire logic [15:0] wr_data_i,        // Write data.
	output logic      [15:0] wr_ea_next_o,     // Updated write pointer.
	// Register-area data from peripherals.
	input  wire logic        sfr_hit_i,        // Address is implemented.
	input  wire logic [15:0] sfr_rdata_i,      // Peripheral read data.
	// Working register byte and extend path.
	input  wire logic [15:0] source_working_register_i, // Old value.
	input  wire logic [1:0]  ext_op_i,         // 0 load,1 byte,2 sign,3 zero.
	output logic      [15:0] wreg_result_o,    // Combined register value.
	// Address error.
	output logic             addr_err_o,       // Misaligned word access.
	output logic             trap_o            // Trap after instruction.
);

	////////////////////////////////////////////////////////////////////////
	// Program counter.

	logic [22:0] pc; // Current program counter.
	logic        cfg_busy; // Copy sequencer still running.

	prog_addr u_pc (
		.clock_i  (clock_i),
		.rst_i    (rst_i),
		.run_i    (!cfg_busy),
		.inc_i    (pc_inc_i),
		.dec_i    (pc_dec_i),
		.load_i   (pc_load_i),
		.target_i (pc_target_i),
		.pc_o     (pc)
	);

	////////////////////////////////////////////////////////////////////////
	// Configuration copy at reset.

	mem_access_pkg::cfg_state_e cfg_q, cfg_d; // Sequencer state.
	logic [15:0] cfgw1_q, cfgw1_d; // Config word one.
	logic [15:0] cfgw2_q, cfgw2_d; // Config word two.

	// Read the two top words, one after the other, before any fetch.
	always_comb begin
		cfg_d   = cfg_q;
		cfgw1_d = cfgw1_q;
		cfgw2_d = cfgw2_q;
		unique case (cfg_q)
			mem_access_pkg::CFG_RD1: begin
				cfg_d = mem_access_pkg::CFG_WAIT1;
			end
			mem_access_pkg::CFG_WAIT1: begin
				cfgw1_d = prog_rdata_i[15:0]; // R8
				cfg_d   = mem_access_pkg::CFG_RD2;
			end
			mem_access_pkg::CFG_RD2: begin
				cfg_d = mem_access_pkg::CFG_WAIT2;
			end
			mem_access_pkg::CFG_WAIT2: begin
				cfgw2_d = prog_rdata_i[15:0]; // R8
				cfg_d   = mem_access_pkg::CFG_DONE;
			end
			mem_access_pkg::CFG_DONE: begin
				cfg_d = mem_access_pkg::CFG_DONE;
			end
		endcase
	end

	// Every reset restarts the copy.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_q   <= mem_access_pkg::CFG_RD1; // R8
			cfgw1_q <= 16'h0000;
			cfgw2_q <= 16'h0000;
		end else begin
			cfg_q   <= cfg_d;
			cfgw1_q <= cfgw1_d;
			cfgw2_q <= cfgw2_d;
		end
	end

	assign cfg_busy       = (cfg_q != mem_access_pkg::CFG_DONE);
	assign busy_o         = cfg_busy;
	assign config_word1_o = cfgw1_q;
	assign config_word2_o = cfgw2_q;

	////////////////////////////////////////////////////////////////////////
	// Program-space address formation.

	logic [23:0] tbl_addr; // Table address from page and offset.
	logic [23:0] psv_addr; // Visibility window address.
	logic        psv_sel;  // Read goes to the window.

	assign tbl_addr = {table_page_register_i, tbl_offset_i}; // R1
	// Window: 32 Kbytes onto a 16K-word boundary set by the page.
	assign psv_addr = {1'b0, visibility_page_register_i,
		rd_ea_i[14:0]}; // R21
	assign psv_sel  = rd_req_i && psv_en_i &&
		rd_ea_i[mem_access_pkg::PSV_BIT]; // R11

	// Upper half is configuration space; only table ops with page bit 7.
	assign tbl_denied_o = tbl_req_i && tbl_addr[23] &&
		!table_page_register_i[mem_access_pkg::TBL_CFG_BIT]; // R3

	// Priority: config copy, table op, window read, then execution fetch.
	always_comb begin
		prog_rd_o = 1'b1;
		// The copy address stands through its wait state, because the word
		// is captured at the end of it; dropping it early reads junk.
		if (cfg_q == mem_access_pkg::CFG_RD1 ||
			cfg_q == mem_access_pkg::CFG_WAIT1) begin
			prog_addr_o = mem_access_pkg::CFG_WORD1; // R8
		end else if (cfg_q == mem_access_pkg::CFG_RD2 ||
			cfg_q == mem_access_pkg::CFG_WAIT2) begin
			prog_addr_o = mem_access_pkg::CFG_WORD2; // R8
		end else if (tbl_req_i) begin
			prog_addr_o = tbl_addr; // R1
			prog_rd_o   = !tbl_denied_o; // R3
		end else if (psv_sel) begin
			prog_addr_o = psv_addr; // R2
		end else begin
			prog_addr_o = {1'b0, pc}; // R1 R2 R6 R7
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data-space address generation units.

	logic rd_mis; // Misaligned word read.
	logic wr_mis; // Misaligned word write.
	logic rd_ram; // Read hits implemented memory.
	logic wr_ram; // Write hits implemented memory.
	logic [1:0] wstrb; // Per-lane strobes.

	// Word access at odd address, seen in the same cycle.
	assign rd_mis = rd_req_i && !rd_byte_i && rd_ea_i[0]; // R17 R23
	assign wr_mis = wr_req_i && !wr_byte_i && wr_ea_i[0]; // R17 R23
	assign addr_err_o = rd_mis || wr_mis; // R23

	// Pointer update scaled by size; the two units are independent.
	assign rd_ea_next_o = rd_postinc_i ? rd_ea_i + (rd_byte_i ?
		mem_access_pkg::STEP_BYTE : mem_access_pkg::STEP_WORD)
		: rd_ea_i; // R9 R14
	assign wr_ea_next_o = wr_postinc_i ? wr_ea_i + (wr_byte_i ?
		mem_access_pkg::STEP_BYTE : mem_access_pkg::STEP_WORD)
		: wr_ea_i; // R9 R14

	assign rd_ram = (rd_ea_i <= mem_access_pkg::RAM_TOP); // R10 R12
	assign wr_ram = wr_req_i && !wr_ea_i[mem_access_pkg::PSV_BIT] &&
		(wr_ea_i <= mem_access_pkg::RAM_TOP) &&
		(wr_ea_i > mem_access_pkg::SFR_TOP); // R11

	// Lane strobes from the byte address; misaligned write suppressed.
	always_comb begin
		wstrb = 2'b00;
		if (wr_ram && !wr_mis) begin // R18
			if (wr_byte_i) begin
				wstrb = wr_ea_i[0] ? 2'b10 : 2'b01; // R13 R16
			end else begin
				wstrb = 2'b11; // R16
			end
		end
	end

	logic [15:0] ram_rdata; // Registered memory word.

	data_ram u_ram (
		.clock_i (clock_i),
		.raddr_i (rd_ea_i[12:1]),
		.rdata_o (ram_rdata),
		.waddr_i (wr_ea_i[12:1]),
		.wstrb_i (wstrb),
		.wdata_i (wr_byte_i ? {wr_data_i[7:0], wr_data_i[7:0]}
			: wr_data_i)
	);

	////////////////////////////////////////////////////////////////////////
	// Read return path, one cycle after the request.

	logic        rv_q, rv_d;       // Read valid.
	logic        rbyte_q, rbyte_d; // Byte read pending.
	logic        rodd_q, rodd_d;   // Odd byte lane.
	logic [1:0]  rsrc_q, rsrc_d;   // 0 zero,1 ram,2 sfr,3 window.
	logic [15:0] sfr_q, sfr_d;     // Captured register-area or window word.
	logic [15:0] word;             // Selected source word.

	// Capture the source of the pending read.
	always_comb begin
		rv_d    = rd_req_i;
		rbyte_d = rd_byte_i;
		rodd_d  = rd_ea_i[0];
		sfr_d   = sfr_hit_i ? sfr_rdata_i : 16'h0000; // R22
		// The window word is taken now; next cycle the bus fetches again.
		if (psv_sel) begin
			sfr_d = prog_rdata_i[15:0]; // R4 R21
		end
		if (rd_ea_i[mem_access_pkg::PSV_BIT]) begin
			rsrc_d = psv_en_i ? 2'h3 : 2'h0; // R11
		end else if (rd_ea_i <= mem_access_pkg::SFR_TOP) begin
			rsrc_d = 2'h2; // R22
		end else if (rd_ram) begin
			rsrc_d = 2'h1;
		end else begin
			rsrc_d = 2'h0; // R12
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rv_q    <= 1'b0;
			rbyte_q <= 1'b0;
			rodd_q  <= 1'b0;
			rsrc_q  <= 2'h0;
			sfr_q   <= 16'h0000;
		end else begin
			rv_q    <= rv_d;
			rbyte_q <= rbyte_d;
			rodd_q  <= rodd_d;
			rsrc_q  <= rsrc_d;
			sfr_q   <= sfr_d;
		end
	end

	// Pick word, then lane; window data uses the lower program word.
	always_comb begin
		unique case (rsrc_q)
			2'h0: word = 16'h0000; // R12
			2'h1: word = ram_rdata;
			2'h2: word = sfr_q;
			2'h3: word = sfr_q; // R4
		endcase
		if (rbyte_q) begin
			rd_data_o = {8'h00, rodd_q ? word[15:8] : word[7:0]}; // R15
		end else begin
			rd_data_o = word;
		end
	end
	assign rd_valid_o = rv_q;

	////////////////////////////////////////////////////////////////////////
	// Working register byte load and extend.

	// Merge a byte into the low half, or extend it.
	always_comb begin
		unique case (ext_op_i)
			2'h0: wreg_result_o = rd_data_o;
			2'h1: wreg_result_o = {source_working_register_i[15:8],
				rd_data_o[7:0]}; // R19
			2'h2: wreg_result_o = {{8{source_working_register_i[7]}},
				source_working_register_i[7:0]}; // R20
			2'h3: wreg_result_o = {8'h00,
				source_working_register_i[7:0]}; // R20
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Trap follows the erring instruction by one cycle.

	logic trap_q, trap_d; // Pending trap.

	always_comb begin
		trap_d = addr_err_o; // R18
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			trap_q <= 1'b0;
		end else begin
			trap_q <= trap_d;
		end
	end
	assign trap_o = trap_q;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	sequence s_copy;
		cfg_q == mem_access_pkg::CFG_RD1 ##2
		cfg_q == mem_access_pkg::CFG_RD2;
	endsequence

	a_cfg_copy_order: assert property (@(posedge clock_i) disable iff (rst_i)
		$rose(cfg_busy) || (cfg_q == mem_access_pkg::CFG_RD1) |-> s_copy)
		else $error("config copy out of order"); // R8
	a_word_odd_err: assert property (@(posedge clock_i) disable iff (rst_i)
		(wr_req_i && !wr_byte_i && wr_ea_i[0]) |-> addr_err_o && wstrb == 2'b00)
		else $error("misaligned write not caught"); // R17
	a_trap_follows: assert property (@(posedge clock_i) disable iff (rst_i)
		addr_err_o |=> trap_o) else $error("trap missing"); // R18
	a_byte_strobe: assert property (@(posedge clock_i) disable iff (rst_i)
		wr_byte_i |-> !(wstrb[0] && wstrb[1]))
		else $error("byte write hit both lanes"); // R16
	a_out_zero: assert property (@(posedge clock_i) disable iff (rst_i)
		rd_req_i && !rd_ea_i[15] && rd_ea_i > 16'h1FFF |=> rd_data_o == 16'h0000)
		else $error("unimplemented read not zero"); // R12
	a_byte_high_zero: assert property (@(posedge clock_i) disable iff (rst_i)
		rd_req_i && rd_byte_i |=> rd_data_o[15:8] == 8'h00)
		else $error("byte read upper not zero"); // R15
	a_postinc_step: assert property (@(posedge clock_i) disable iff (rst_i)
		rd_postinc_i && !rd_byte_i |-> rd_ea_next_o == rd_ea_i + 16'h0002)
		else $error("word post-increment wrong"); // R14
	a_tbl_guard: assert property (@(posedge clock_i) disable iff (rst_i)
		tbl_req_i && !cfg_busy && !table_page_register_i[7] |-> !prog_addr_o[23] || !prog_rd_o)
		else $error("config space reached without page bit"); // R3
	a_no_fetch_busy: assert property (@(posedge clock_i) disable iff (rst_i)
		cfg_busy |-> prog_addr_o != {1'b0, pc} || pc == 23'h0)
		else $error("fetch during config copy"); // R6

endmodule : memory_space_access
`default_nettype wire

// file: prog_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Program memory stand-in that answers in the same cycle as the address.
module prog_mem_model (
	input  wire logic        rd_i,    // Read strobe.
	input  wire logic [23:0] addr_i,  // Word address.
	output logic      [23:0] rdata_o  // Instruction word.
);
	// Content is a fixed function of the address, so the bench can predict it.
	// With no strobe the bus is released; showing the inverse exposes stale use.
	always_comb begin
		rdata_o = {addr_i[7:0] ^ 8'h3C,
			addr_i[15:0] ^ {addr_i[23:16], addr_i[23:16]} ^ 16'h5A5A};
		if (!rd_i) begin
			rdata_o = ~rdata_o;
		end
	end
endmodule : prog_mem_model
`default_nettype wire

// file: memory_space_access_bench.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the address-space and access logic.
module memory_space_access_bench;
	logic        clock_i = 1'b0, rst_i = 1'b1;      // Clock and reset.
	logic        pc_inc_i = 1'b0, pc_dec_i = 1'b0;  // Counter steps.
	logic        pc_load_i = 1'b0, tbl_req_i = 1'b0; // Jump and table op.
	logic [22:0] pc_target_i = '0;                  // Jump target.
	logic [23:0] prog_rdata_i, prog_addr_o;         // Program bus.
	logic [7:0]  table_page_register_i = '0, visibility_page_register_i = '0;
	logic [15:0] tbl_offset_i = '0, rd_ea_i = '0, wr_ea_i = '0;
	logic        psv_en_i = 1'b0, rd_req_i = 1'b0, rd_byte_i = 1'b0;
	logic        rd_postinc_i = 1'b1, wr_req_i = 1'b0, wr_byte_i = 1'b0;
	logic        wr_postinc_i = 1'b1, sfr_hit_i = 1'b0;
	logic [15:0] wr_data_i = '0, sfr_rdata_i = '0;
	logic [15:0] source_working_register_i = '0;    // Old register value.
	logic [1:0]  ext_op_i = '0;                     // Extend selection.
	logic        prog_rd_o, busy_o, tbl_denied_o, rd_valid_o, addr_err_o;
	logic        trap_o;
	logic [15:0] config_word1_o, config_word2_o, rd_ea_next_o, rd_data_o;
	logic [15:0] wr_ea_next_o, wreg_result_o;
	int          failures = 0, n_compared = 0;      // Verdict counters.

	memory_space_access dut_u (.clock_i, .rst_i, .pc_inc_i, .pc_dec_i,
		.pc_load_i, .pc_target_i, .prog_addr_o, .prog_rd_o, .prog_rdata_i,
		.busy_o, .config_word1_o, .config_word2_o, .tbl_req_i,
		.table_page_register_i, .tbl_offset_i, .tbl_denied_o, .psv_en_i,
		.visibility_page_register_i, .rd_req_i, .rd_byte_i, .rd_ea_i,
		.rd_postinc_i, .rd_ea_next_o, .rd_valid_o, .rd_data_o, .wr_req_i,
		.wr_byte_i, .wr_ea_i, .wr_postinc_i, .wr_data_i, .wr_ea_next_o,
		.sfr_hit_i, .sfr_rdata_i, .source_working_register_i, .ext_op_i,
		.wreg_result_o, .addr_err_o, .trap_o);

	prog_mem_model mem_u (.rd_i(prog_rd_o), .addr_i(prog_addr_o),
		.rdata_o(prog_rdata_i));

	// 50 MHz core clock.
	always #10 clock_i = ~clock_i;

	////////////////////////////////////////////////////////////////////////
	// Expected lower program word, mirroring the memory model's content.
	function automatic logic [15:0] pm16(input logic [23:0] a);
		return a[15:0] ^ {a[23:16], a[23:16]} ^ 16'h5A5A;
	endfunction : pm16

	// Compares a seen value with the expected one and counts both.
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Waits n rising edges, then returns one nanosecond after the last one.
	task automatic step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : step

	// One data access with in-cycle error and pointer checks, then the answer.
	task automatic access(input logic wr, input logic byt,
		input logic [15:0] ea, input logic [15:0] d, input logic err,
		input logic [15:0] exp);
		logic [15:0] nx;
		nx = ea + (byt ? 16'h0001 : 16'h0002);
		if (wr) begin
			wr_req_i = 1'b1;
			wr_byte_i = byt;
			wr_ea_i = ea;
			wr_data_i = d;
		end else begin
			rd_req_i = 1'b1;
			rd_byte_i = byt;
			rd_ea_i = ea;
		end
		#1;
		check(addr_err_o, err);
		check(wr ? wr_ea_next_o : rd_ea_next_o, nx);
		step(1);
		rd_req_i = 1'b0;
		wr_req_i = 1'b0;
		#1;
		check(trap_o, err);
		// A misaligned read still returns valid data from the aligned word, but its valid flag and data are not checked.
		if (!wr && !err) begin
			check(rd_valid_o, 1'b1);
			check(rd_data_o, exp);
		end
	endtask : access

	////////////////////////////////////////////////////////////////////////
	// Reset, configuration copy and the first fetch address.
	task automatic t_reset;
		int k;
		rst_i = 1'b1;
		step(8);
		check(busy_o, 1'b1);
		check(trap_o, 1'b0);
		rst_i = 1'b0;
		k = 0;
		// Bounded wait: the copy takes a handful of cycles.
		while (busy_o === 1'b1 && k < 20) begin
			step(1);
			k++;
		end
		check(k <= 5, 1'b1);
		check(config_word1_o, pm16(mem_access_pkg::CFG_WORD1));
		check(config_word2_o, pm16(mem_access_pkg::CFG_WORD2));
		check(prog_addr_o, mem_access_pkg::RESET_ADDR);
		$display("test reset done");
	endtask : t_reset

	// Counter steps by two both ways and jumps into the vector area.
	task automatic t_pc;
		pc_inc_i = 1'b1;
		step(3);
		pc_inc_i = 1'b0;
		#1;
		check(prog_addr_o, 24'h000006);
		pc_dec_i = 1'b1;
		step(1);
		pc_dec_i = 1'b0;
		#1;
		check(prog_addr_o, 24'h000004);
		pc_target_i = 23'h000102;
		pc_load_i = 1'b1;
		step(1);
		pc_load_i = 1'b0;
		#1;
		check(prog_addr_o, 24'h000102);
		check(prog_rd_o, 1'b1);
		$display("test counter done");
	endtask : t_pc

	// Table path: configuration area with the page bit, user area without.
	task automatic t_table;
		tbl_req_i = 1'b1;
		tbl_offset_i = 16'hFFF0;
		table_page_register_i = 8'h80;
		#1;
		check(prog_addr_o, 24'h80FFF0);
		check(tbl_denied_o, 1'b0);
		table_page_register_i = 8'h12;
		#1;
		check(prog_addr_o, 24'h12FFF0);
		step(1);
		tbl_req_i = 1'b0;
		$display("test table done");
	endtask : t_table

	// Lanes, alignment errors, empty space and the visibility window.
	task automatic t_data;
		access(1, 0, 16'h0802, 16'h1234, 0, '0);
		access(0, 1, 16'h0803, '0, 0, 16'h0012);
		access(1, 1, 16'h0802, 16'hABAB, 0, '0);
		access(1, 1, 16'h0803, 16'hCDCD, 0, '0);
		access(1, 0, 16'h0803, 16'h7777, 1, '0);
		access(0, 0, 16'h0802, '0, 0, 16'hCDAB);
		access(0, 0, 16'h0803, '0, 1, '0);
		access(1, 0, 16'h1FFE, 16'h55AA, 0, '0);
		access(0, 0, 16'h1FFE, '0, 0, 16'h55AA);
		access(0, 0, 16'h2000, '0, 0, 16'h0000);
		access(0, 0, 16'h0400, '0, 0, 16'h0000);
		sfr_hit_i = 1'b1;
		sfr_rdata_i = 16'hBEEF;
		access(0, 0, 16'h0400, '0, 0, 16'hBEEF);
		sfr_hit_i = 1'b0;
		psv_en_i = 1'b1;
		visibility_page_register_i = 8'h02;
		access(0, 0, 16'h8006, '0, 0, pm16(24'h010006));
		psv_en_i = 1'b0;
		$display("test data done");
	endtask : t_data

	// Byte load, sign and zero extension on one negative byte.
	task automatic t_ext;
		logic [15:0] exp [4];
		exp = '{16'h0085, 16'h3385, 16'hFF85, 16'h0085};
		access(1, 0, 16'h0806, 16'h8585, 0, '0);
		source_working_register_i = 16'h3385;
		access(0, 1, 16'h0807, '0, 0, 16'h0085);
		for (int i = 0; i < 4; i++) begin
			ext_op_i = 2'(i);
			#1;
			check(wreg_result_o, exp[i]);
		end
		// Without post-increment the pointer must come back unchanged.
		rd_postinc_i = 1'b0;
		#1;
		check(rd_ea_next_o, 16'h0807);
		rd_postinc_i = 1'b1;
		$display("test extend done");
	endtask : t_ext

	////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict

	// Main sequence; the second reset checks that the copy repeats.
	initial begin
		t_reset();
		t_pc();
		t_table();
		t_data();
		t_ext();
		t_reset();
		give_verdict();
	end

	// Watchdog well beyond the fifty or so cycles the tests need.
	initial begin
		#80000;
		failures++;
		$display("ERROR at %0t: timeout", $time);
		give_verdict();
	end
endmodule : memory_space_access_bench
`default_nettype wire
